/* File: design/cfl_pkg.sv */
package cfl_pkg;
  // ********************
  // formats
  // ********************
  localparam int COORD_W = 16;          // s, t, r: signed Q4.12
  localparam int COORD_FRAC = 12;
  localparam int TEXEL_W = 24;          // u, v, w: signed Q16.8
  localparam int LOD_W = 16;            // lod, bias, rho: Q8.8
  localparam int LOD_FRAC = 8;
  localparam int SIZE_W = 13;
  localparam int OFF_W = 6;             // integer texel offsets
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ********************
  // register map (byte addresses)
  // ********************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BIAS = 8'h04;
  localparam logic [7:0] ADDR_LOD_MIN = 8'h08;
  localparam logic [7:0] ADDR_LOD_MAX = 8'h0C;
  localparam logic [7:0] ADDR_SIZE_WH = 8'h10;
  localparam logic [7:0] ADDR_SIZE_D = 8'h14;
  localparam logic [7:0] ADDR_COUNT = 8'h18;

  // ctrl fields
  localparam int CTRL_SEAMLESS = 0;
  localparam int CTRL_BILINEAR = 1;
  localparam int CTRL_TYPE_LSB = 2;
  localparam int CTRL_WRAP_S_LSB = 5;
  localparam int CTRL_WRAP_T_LSB = 7;
  localparam int CTRL_WRAP_R_LSB = 9;
  localparam int SIZE_H_LSB = 16;

  // reset values; lod limits at the extremes clamp only a log2-of-zero lod with a negative bias
  localparam logic [15:0] RST_LOD_MIN = 16'h8000;
  localparam logic [15:0] RST_LOD_MAX = 16'h7FFF;
  localparam logic [12:0] RST_SIZE = 13'h0001;

  // implementation constants
  localparam logic signed [15:0] BIAS_MAX = 16'sh1000;   // 16.0
  localparam logic signed [15:0] LOD_C = 16'sh0000;      // mag/min transition
  localparam logic signed [15:0] LOD_FLOOR = 16'sh8000;  // log2 of zero
  localparam logic [12:0] ONE_Q12 = 13'h1000;

  // wrap codes
  localparam logic [1:0] WRAP_EDGE_CLAMP = 2'h0;
  localparam logic [1:0] WRAP_REPEAT = 2'h1;
  localparam logic [1:0] WRAP_BORDER_CLAMP = 2'h2;
  localparam logic [1:0] WRAP_MIRROR = 2'h3;

  // texture kinds
  localparam logic [2:0] TEX_1D = 3'h0;
  localparam logic [2:0] TEX_1D_ARRAY = 3'h1;
  localparam logic [2:0] TEX_2D = 3'h2;
  localparam logic [2:0] TEX_2D_ARRAY = 3'h3;
  localparam logic [2:0] TEX_RECT = 3'h4;
  localparam logic [2:0] TEX_CUBE = 3'h5;
  localparam logic [2:0] TEX_3D = 3'h6;

  // cube faces
  localparam logic [2:0] FACE_PX = 3'h0;
  localparam logic [2:0] FACE_NX = 3'h1;
  localparam logic [2:0] FACE_PY = 3'h2;
  localparam logic [2:0] FACE_NY = 3'h3;
  localparam logic [2:0] FACE_PZ = 3'h4;
  localparam logic [2:0] FACE_NZ = 3'h5;
endpackage

/* File: design/cfl_top.sv */
`timescale 1ns/1ps
module cfl_top
  import cfl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [cfl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cfl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [cfl_pkg::DATA_W-1:0] reg_rdata,
  input wire logic in_valid,
  input wire logic signed [cfl_pkg::COORD_W-1:0] in_s,
  input wire logic signed [cfl_pkg::COORD_W-1:0] in_t,
  input wire logic signed [cfl_pkg::COORD_W-1:0] in_r,
  input wire logic in_has_bias,
  input wire logic in_from_frag,
  input wire logic signed [cfl_pkg::LOD_W-1:0] in_bias,
  input wire logic in_has_offset,
  input wire logic signed [cfl_pkg::OFF_W-1:0] in_off_u,
  input wire logic signed [cfl_pkg::OFF_W-1:0] in_off_v,
  input wire logic signed [cfl_pkg::OFF_W-1:0] in_off_w,
  input wire logic signed [cfl_pkg::LOD_W-1:0] in_dudx,
  input wire logic signed [cfl_pkg::LOD_W-1:0] in_dvdx,
  input wire logic signed [cfl_pkg::LOD_W-1:0] in_dwdx,
  input wire logic signed [cfl_pkg::LOD_W-1:0] in_dudy,
  input wire logic signed [cfl_pkg::LOD_W-1:0] in_dvdy,
  input wire logic signed [cfl_pkg::LOD_W-1:0] in_dwdy,
  input wire logic in_is_line,
  input wire logic signed [cfl_pkg::LOD_W-1:0] in_line_dx,
  input wire logic signed [cfl_pkg::LOD_W-1:0] in_line_dy,
  output logic out_valid,
  output logic [2:0] out_face,
  output logic signed [cfl_pkg::TEXEL_W-1:0] out_u,
  output logic signed [cfl_pkg::TEXEL_W-1:0] out_v,
  output logic signed [cfl_pkg::TEXEL_W-1:0] out_w,
  output logic signed [cfl_pkg::LOD_W-1:0] out_lod,
  output logic out_mag,
  output logic [1:0] out_wrap_s,
  output logic [1:0] out_wrap_t,
  output logic [1:0] out_wrap_r,
  output logic out_seam_fetch,
  output logic out_corner_avg
);
  import cfl_pkg::*;

  function automatic logic [15:0] abs16(input logic signed [15:0] a);
    abs16 = a[15] ? 16'(-a) : 16'(a);
  endfunction

  function automatic logic [15:0] max3(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] c);
    logic [15:0] m;
    m = (a > b) ? a : b;
    max3 = (m > c) ? m : c;
  endfunction

  // continuous, monotonic log2: integer from leading one, fraction linear from the 8 bits below it
  function automatic logic signed [15:0] log2_q8(input logic [15:0] v);
    logic [15:0] norm;
    logic [4:0] p;
    p = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        p = 5'(i);
      end
    end
    norm = v << (5'h0F - p);
    if (v == 16'h0000) begin
      log2_q8 = LOD_FLOOR;
    end else begin
      log2_q8 = {8'(signed'({1'b0, p}) - 6'sd8), norm[14:7]};
    end
  endfunction

  // ********************
  // registers
  // ********************
  logic ctl_seamless;
  logic ctl_bilinear;
  logic [2:0] ctl_type;
  logic [5:0] ctl_wrap;
  logic signed [15:0] ctl_bias;
  logic signed [15:0] ctl_lod_min;
  logic signed [15:0] ctl_lod_max;
  logic [12:0] ctl_w;
  logic [12:0] ctl_h;
  logic [12:0] ctl_d;
  logic [31:0] sample_count;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl_seamless <= 1'b0;
      ctl_bilinear <= 1'b0;
      ctl_type <= TEX_2D;
      ctl_wrap <= 6'h00;
      ctl_bias <= 16'sh0000;
      ctl_lod_min <= RST_LOD_MIN;
      ctl_lod_max <= RST_LOD_MAX;
      ctl_w <= RST_SIZE;
      ctl_h <= RST_SIZE;
      ctl_d <= RST_SIZE;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CTRL: begin
          ctl_seamless <= reg_wdata[CTRL_SEAMLESS];
          ctl_bilinear <= reg_wdata[CTRL_BILINEAR];
          ctl_type <= reg_wdata[CTRL_TYPE_LSB +: 3];
          ctl_wrap <= reg_wdata[CTRL_WRAP_S_LSB +: 6];
        end
        ADDR_BIAS: ctl_bias <= reg_wdata[15:0];
        ADDR_LOD_MIN: ctl_lod_min <= reg_wdata[15:0];
        ADDR_LOD_MAX: ctl_lod_max <= reg_wdata[15:0];
        ADDR_SIZE_WH: begin
          ctl_w <= reg_wdata[12:0];
          ctl_h <= reg_wdata[SIZE_H_LSB +: 13];
        end
        ADDR_SIZE_D: ctl_d <= reg_wdata[12:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CTRL: reg_rdata <= {21'h0, ctl_wrap, ctl_type, ctl_bilinear, ctl_seamless};
        ADDR_BIAS: reg_rdata <= {16'h0000, ctl_bias};
        ADDR_LOD_MIN: reg_rdata <= {16'h0000, ctl_lod_min};
        ADDR_LOD_MAX: reg_rdata <= {16'h0000, ctl_lod_max};
        ADDR_SIZE_WH: reg_rdata <= {3'h0, ctl_h, 3'h0, ctl_w};
        ADDR_SIZE_D: reg_rdata <= {19'h0, ctl_d};
        ADDR_COUNT: reg_rdata <= sample_count;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sample_count <= 32'h0000_0000;
    end else if (out_valid) begin
      sample_count <= sample_count + 32'h0000_0001;
    end
  end

  // ********************
  // stage 1: face select, scale factor
  // ********************
  logic [15:0] ax, ay, az;
  logic [2:0] next_face;
  logic signed [15:0] next_sc, next_tc;
  logic [15:0] next_ma;
  logic [15:0] mu, mv, mw, next_rho;
  logic signed [31:0] pu, pv, pw;
  logic has_v, has_w;

  assign ax = abs16(in_s);
  assign ay = abs16(in_t);
  assign az = abs16(in_r);
  // q is not an input at all: it only scales the direction
  assign has_v = !(ctl_type == TEX_1D || ctl_type == TEX_1D_ARRAY);
  assign has_w = (ctl_type == TEX_3D);

  always_comb begin
    // ties favour x, then y, so equal magnitudes always give the same face
    if (ax >= ay && ax >= az) begin
      next_ma = ax;
      next_face = in_s[15] ? FACE_NX : FACE_PX;
      next_sc = in_s[15] ? in_r : 16'(-in_r);
      next_tc = 16'(-in_t);
    end else if (ay >= az) begin
      next_ma = ay;
      next_face = in_t[15] ? FACE_NY : FACE_PY;
      next_sc = in_s;
      next_tc = in_t[15] ? 16'(-in_r) : in_r;
    end else begin
      next_ma = az;
      next_face = in_r[15] ? FACE_NZ : FACE_PZ;
      next_sc = in_r[15] ? 16'(-in_s) : in_s;
      next_tc = 16'(-in_t);
    end
  end

  // max-norm approximation: monotonic and inside the max/sum bounds
  always_comb begin
    pu = (in_dudx * in_line_dx + in_dudy * in_line_dy) >>> 14;
    pv = (in_dvdx * in_line_dx + in_dvdy * in_line_dy) >>> 14;
    pw = (in_dwdx * in_line_dx + in_dwdy * in_line_dy) >>> 14;
    if (in_is_line) begin
      mu = abs16(pu[15:0]);
      mv = has_v ? abs16(pv[15:0]) : 16'h0000;
      mw = has_w ? abs16(pw[15:0]) : 16'h0000;
    end else begin
      mu = max3(abs16(in_dudx), abs16(in_dudy), 16'h0000);
      mv = has_v ? max3(abs16(in_dvdx), abs16(in_dvdy), 16'h0000) : 16'h0000;
      mw = has_w ? max3(abs16(in_dwdx), abs16(in_dwdy), 16'h0000) : 16'h0000;
    end
    next_rho = max3(mu, mv, mw);
  end

  logic s1_valid;
  logic [2:0] s1_face, s1_type;
  logic signed [15:0] s1_sc, s1_tc, s1_s, s1_t, s1_r, s1_bias;
  logic [15:0] s1_ma, s1_rho;
  logic signed [5:0] s1_off_u, s1_off_v, s1_off_w;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s1_valid <= 1'b0;
    end else begin
      s1_valid <= in_valid;
    end
  end

  always_ff @(posedge core_clk) begin
    s1_face <= next_face;
    s1_type <= ctl_type;
    s1_sc <= next_sc;
    s1_tc <= next_tc;
    s1_ma <= next_ma;
    s1_rho <= next_rho;
    s1_s <= in_s;
    s1_t <= in_t;
    s1_r <= in_r;
    s1_bias <= (in_has_bias && in_from_frag) ? in_bias : 16'sh0000;
    s1_off_u <= in_has_offset ? in_off_u : 6'sh00;
    s1_off_v <= in_has_offset ? in_off_v : 6'sh00;
    s1_off_w <= in_has_offset ? in_off_w : 6'sh00;
  end

  // ********************
  // stage 2: projection, texel space, log2
  // ********************
  logic signed [28:0] qs, qt;
  logic signed [13:0] fs, ft;
  logic signed [15:0] cs, ct;
  logic signed [16:0] sum_bias;
  logic signed [15:0] next_bias;
  logic signed [29:0] mul_u, mul_v, mul_w;
  logic signed [23:0] next_u, next_v, next_w;

  always_comb begin
    if (s1_ma == 16'h0000) begin
      qs = 29'sd0;
      qt = 29'sd0;
    end else begin
      qs = (29'(s1_sc) <<< COORD_FRAC) / signed'({13'h0, s1_ma});
      qt = (29'(s1_tc) <<< COORD_FRAC) / signed'({13'h0, s1_ma});
    end
    fs = 14'((qs + 29'(ONE_Q12)) >>> 1);
    ft = 14'((qt + 29'(ONE_Q12)) >>> 1);
    cs = (s1_type == TEX_CUBE) ? 16'(fs) : s1_s;
    ct = (s1_type == TEX_CUBE) ? 16'(ft) : s1_t;
    mul_u = cs * signed'({1'b0, ctl_w});
    mul_v = ct * signed'({1'b0, ctl_h});
    mul_w = s1_r * signed'({1'b0, ctl_d});
    if (s1_type == TEX_RECT) begin
      next_u = 24'(cs >>> 4) + (24'(s1_off_u) <<< LOD_FRAC);
      next_v = 24'(ct >>> 4) + (24'(s1_off_v) <<< LOD_FRAC);
    end else begin
      next_u = 24'(mul_u >>> 4) + (24'(s1_off_u) <<< LOD_FRAC);
      next_v = 24'(mul_v >>> 4) + (24'(s1_off_v) <<< LOD_FRAC);
    end
    next_w = 24'(mul_w >>> 4) + (24'(s1_off_w) <<< LOD_FRAC);
    if (s1_type == TEX_1D || s1_type == TEX_1D_ARRAY) begin
      next_v = 24'sh000000;
    end
    if (s1_type != TEX_3D) begin
      next_w = 24'sh000000;
    end
    sum_bias = 17'(ctl_bias) + 17'(s1_bias);
    if (sum_bias > 17'(BIAS_MAX)) begin
      next_bias = BIAS_MAX;
    end else if (sum_bias < -17'(BIAS_MAX)) begin
      next_bias = 16'(-BIAS_MAX);
    end else begin
      next_bias = 16'(sum_bias);
    end
  end

  logic s2_valid;
  logic [2:0] s2_face, s2_type;
  logic signed [23:0] s2_u, s2_v, s2_w;
  logic signed [15:0] s2_lod_base, s2_bias;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s2_valid <= 1'b0;
    end else begin
      s2_valid <= s1_valid;
    end
  end

  always_ff @(posedge core_clk) begin
    s2_face <= s1_face;
    s2_type <= s1_type;
    s2_u <= next_u;
    s2_v <= next_v;
    s2_w <= next_w;
    s2_lod_base <= log2_q8(s1_rho);
    s2_bias <= next_bias;
  end

  // ********************
  // stage 3: lod clamp, classification, wrap steering
  // ********************
  logic signed [16:0] lod_sum;
  logic signed [15:0] next_lod;
  logic seam_on;

  always_comb begin
    lod_sum = 17'(s2_lod_base) + 17'(s2_bias);
    if (lod_sum > 17'(ctl_lod_max)) begin
      next_lod = ctl_lod_max;
    end else if (lod_sum < 17'(ctl_lod_min)) begin
      next_lod = ctl_lod_min;
    end else begin
      next_lod = 16'(lod_sum);
    end
  end

  assign seam_on = ctl_seamless && (s2_type == TEX_CUBE);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_face <= FACE_PX;
      out_u <= 24'sh000000;
      out_v <= 24'sh000000;
      out_w <= 24'sh000000;
      out_lod <= 16'sh0000;
      out_mag <= 1'b0;
      out_wrap_s <= WRAP_EDGE_CLAMP;
      out_wrap_t <= WRAP_EDGE_CLAMP;
      out_wrap_r <= WRAP_EDGE_CLAMP;
      out_seam_fetch <= 1'b0;
      out_corner_avg <= 1'b0;
    end else begin
      out_valid <= s2_valid;
      out_face <= s2_face;
      out_u <= s2_u;
      out_v <= s2_v;
      out_w <= s2_w;
      out_lod <= next_lod;
      out_mag <= (next_lod <= LOD_C);
      if (!seam_on) begin
        out_wrap_s <= ctl_wrap[1:0];
        out_wrap_t <= ctl_wrap[3:2];
        out_wrap_r <= ctl_wrap[5:4];
      end else if (ctl_bilinear) begin
        out_wrap_s <= WRAP_BORDER_CLAMP;
        out_wrap_t <= WRAP_BORDER_CLAMP;
        out_wrap_r <= WRAP_BORDER_CLAMP;
      end else begin
        out_wrap_s <= WRAP_EDGE_CLAMP;
        out_wrap_t <= WRAP_EDGE_CLAMP;
        out_wrap_r <= WRAP_EDGE_CLAMP;
      end
      // the fetch stage takes border texels from the neighbour face and,
      // in a corner, averages the three real ones
      out_seam_fetch <= seam_on && ctl_bilinear;
      out_corner_avg <= seam_on && ctl_bilinear;
    end
  end

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence px_major;
    in_valid && !in_s[15] && ax > ay && ax > az;
  endsequence

  a_face_major: assert property (px_major |-> ##3 out_valid && out_face == FACE_PX)
    else $error("positive x major axis did not select face 0");
  a_tie_break: assert property (in_valid && ax == ay && ax >= az && in_t[15] == in_s[15]
    |-> ##3 out_face == ($past(in_s[15], 3) ? FACE_NX : FACE_PX))
    else $error("tie between x and y not resolved to x");
  // the default disable would swallow every attempt that starts in reset
  a_seam_reset: assert property (@(posedge core_clk) disable iff (1'b0)
    rst |=> !ctl_seamless)
    else $error("seamless enable not cleared by reset");
  a_dim_zero: assert property (out_valid && $past(ctl_type, 3) == TEX_1D && !$past(reg_wr, 3)
    |-> out_v == 24'sh000000 && out_w == 24'sh000000)
    else $error("1D sample carries nonzero v or w");
  a_lod_clamp: assert property (out_valid && $past(ctl_lod_min) <= $past(ctl_lod_max)
    |-> out_lod >= $past(ctl_lod_min) && out_lod <= $past(ctl_lod_max))
    else $error("lod outside min/max limits");
  a_mag_class: assert property (s2_valid |=> out_mag == (out_lod <= LOD_C))
    else $error("magnify flag disagrees with lod");
  a_bias_range: assert property (s1_valid |-> next_bias <= BIAS_MAX
    && next_bias >= -BIAS_MAX)
    else $error("combined bias outside range");
  a_no_shader_bias: assert property (in_valid && !in_has_bias |=> s1_bias == 16'sh0000)
    else $error("shader bias used without bias operand");
  a_point_edge: assert property (s2_valid && seam_on && !ctl_bilinear && !reg_wr
    |=> out_wrap_s == WRAP_EDGE_CLAMP && out_wrap_t == WRAP_EDGE_CLAMP)
    else $error("seamless point sample not edge clamped");
  a_cube_range: assert property (s1_valid && s1_type == TEX_CUBE
    |-> fs >= 14'sd0 && fs <= 14'sd4096 && ft >= 14'sd0 && ft <= 14'sd4096)
    else $error("cube face coordinate outside unit range");

endmodule // cfl_top

/* File: bench/cfl_src.sv */
`timescale 1ns/1ps
// ********************
// upstream sample source
// ********************
module cfl_src
  import cfl_pkg::*;
(
  input wire logic core_clk,
  output logic in_valid,
  output logic signed [15:0] in_s,
  output logic signed [15:0] in_t,
  output logic signed [15:0] in_r,
  output logic in_has_bias,
  output logic in_from_frag,
  output logic signed [15:0] in_bias,
  output logic in_has_offset,
  output logic signed [5:0] in_off_u,
  output logic signed [5:0] in_off_v,
  output logic signed [5:0] in_off_w,
  output logic signed [15:0] in_dudx,
  output logic signed [15:0] in_dvdx,
  output logic signed [15:0] in_dwdx,
  output logic signed [15:0] in_dudy,
  output logic signed [15:0] in_dvdy,
  output logic signed [15:0] in_dwdy,
  output logic in_is_line,
  output logic signed [15:0] in_line_dx,
  output logic signed [15:0] in_line_dy
);
  // one sample per call; valid is left high so calls can run back to back
  task automatic send(input logic signed [15:0] s, t, r);
    in_valid <= 1'b1;
    in_s <= s;
    in_t <= t;
    in_r <= r;
    @(posedge core_clk);
  endtask

  // released coordinates flip so a stale value never passes for a live one
  task automatic idle();
    in_valid <= 1'b0;
    in_s <= ~in_s;
    in_t <= ~in_t;
    in_r <= ~in_r;
  endtask

  task automatic opts(input logic hb, ff, input logic signed [15:0] b, input logic ho,
                      input logic signed [5:0] ou, ov, ow);
    in_has_bias <= hb;
    in_from_frag <= ff;
    in_bias <= b;
    in_has_offset <= ho;
    // offsets stay inside the signed field; junk when the lookup has none
    in_off_u <= ho ? ou : ~ou;
    in_off_v <= ho ? ov : ~ov;
    in_off_w <= ho ? ow : ~ow;
  endtask

  task automatic derivs(input logic signed [15:0] b, input int hi,
                        input logic signed [15:0] hv);
    in_dudx <= (hi == 0) ? hv : b;
    in_dvdx <= (hi == 1) ? hv : b;
    in_dwdx <= (hi == 2) ? hv : b;
    in_dudy <= (hi == 3) ? hv : b;
    in_dvdy <= (hi == 4) ? hv : b;
    in_dwdy <= (hi == 5) ? hv : b;
  endtask

  task automatic line(input logic il, input logic signed [15:0] dx, dy);
    in_is_line <= il;
    in_line_dx <= dx;
    in_line_dy <= dy;
  endtask

  initial begin
    in_valid = 1'b0;
    in_s = 16'sh0;
    in_t = 16'sh0;
    in_r = 16'sh0;
    opts(1'b0, 1'b0, 16'sh0700, 1'b0, 6'sh15, 6'sh15, 6'sh15);
    derivs(16'sh0100, 6, 16'sh0);
    line(1'b0, 16'sh0, 16'sh0);
  end
endmodule // cfl_src

/* File: bench/cube_face_select_lod_calc_test.sv */
`timescale 1ns/1ps
module cube_face_select_lod_calc_test;
  import cfl_pkg::*;
  logic core_clk, rst, reg_wr, reg_rd, in_valid, in_has_bias, in_from_frag, in_has_offset;
  logic in_is_line, out_valid, out_mag, out_seam_fetch, out_corner_avg;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic signed [15:0] in_s, in_t, in_r, in_bias, in_dudx, in_dvdx, in_dwdx, in_dudy;
  logic signed [15:0] in_dvdy, in_dwdy, in_line_dx, in_line_dy, out_lod;
  logic signed [5:0] in_off_u, in_off_v, in_off_w;
  logic signed [23:0] out_u, out_v, out_w;
  logic [2:0] out_face;
  logic [1:0] out_wrap_s, out_wrap_t, out_wrap_r;
  int num_errors, n_checks, n_smp;

  cfl_top u_cfl_top (
    .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .in_valid,
    .in_s, .in_t, .in_r, .in_has_bias, .in_from_frag, .in_bias, .in_has_offset,
    .in_off_u, .in_off_v, .in_off_w, .in_dudx, .in_dvdx, .in_dwdx, .in_dudy, .in_dvdy,
    .in_dwdy, .in_is_line, .in_line_dx, .in_line_dy, .out_valid, .out_face, .out_u,
    .out_v, .out_w, .out_lod, .out_mag, .out_wrap_s, .out_wrap_t, .out_wrap_r,
    .out_seam_fetch, .out_corner_avg
  );

  cfl_src u_cfl_src (
    .core_clk, .in_valid, .in_s, .in_t, .in_r, .in_has_bias, .in_from_frag, .in_bias,
    .in_has_offset, .in_off_u, .in_off_v, .in_off_w, .in_dudx, .in_dvdx, .in_dwdx,
    .in_dudy, .in_dvdy, .in_dwdy, .in_is_line, .in_line_dx, .in_line_dy
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ********************
  // helpers
  // ********************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, e);
  endtask

  // one sample; the answer must stand exactly two cycles after it is taken
  task automatic smp(input logic signed [15:0] s, t, r);
    int k;
    u_cfl_src.send(s, t, r);
    u_cfl_src.idle();
    k = 0;
    do begin
      @(posedge core_clk);
      #1;
      k++;
    end while (out_valid !== 1'b1 && k < 8);
    n_smp++;
    chk("latency", k, 2);
    if (k == 8) stop_test();
  endtask

  task automatic out_chk(input logic [2:0] f, input logic [23:0] u, v, w,
                         input logic [15:0] lod, input logic mag);
    if (f != 3'h7) chk("face", {29'h0, out_face}, {29'h0, f});
    chk("u", {8'h0, out_u}, {8'h0, u});
    chk("v", {8'h0, out_v}, {8'h0, v});
    chk("w", {8'h0, out_w}, {8'h0, w});
    chk("lod", {16'h0, out_lod}, {16'h0, lod});
    chk("mag", {31'h0, out_mag}, {31'h0, mag});
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic t_regs();
    logic [7:0] a[8] = '{ADDR_CTRL, ADDR_BIAS, ADDR_LOD_MIN, ADDR_LOD_MAX, ADDR_SIZE_WH,
                         ADDR_SIZE_D, ADDR_COUNT, 8'h20};
    logic [31:0] e[8] = '{32'h8, 32'h0, 32'h8000, 32'h7FFF, 32'h0001_0001, 32'h1, 32'h0, 32'h0};
    wr(ADDR_COUNT, 32'hFF);
    wr(8'h20, 32'hFFFF);
    for (int i = 0; i < 8; i++) rd(a[i], e[i]);
    $display("t_regs done");
  endtask

  task automatic t_faces();
    int c[24] = '{2, 1, 0, -2, 0, 1, 1, 2, 0, 0, -2, 1, 1, 0, 2, 0, 1, -2, 2, 2, 2, 0, -2, -2};
    logic [2:0] f[8] = '{0, 1, 2, 3, 4, 5, 0, 3};
    logic [7:0] u[8] = '{4, 6, 6, 4, 6, 4, 0, 4};
    logic [7:0] v[8] = '{2, 4, 4, 2, 4, 2, 0, 8};
    wr(ADDR_CTRL, 32'h14);
    wr(ADDR_SIZE_WH, 32'h0008_0008);
    for (int i = 0; i < 8; i++) begin
      smp(16'(c[3*i] * 2048), 16'(c[3*i+1] * 2048), 16'(c[3*i+2] * 2048));
      out_chk(f[i], {8'h0, u[i], 8'h0}, {8'h0, v[i], 8'h0}, 24'h0, 16'h0, 1'b1);
    end
    $display("t_faces done");
  endtask

  task automatic t_lod();
    wr(ADDR_CTRL, 32'h8);
    for (int i = 0; i < 6; i++) begin
      u_cfl_src.derivs(16'sh0100, i, (i == 5) ? -16'sh0400 : 16'sh0400);
      smp(16'sh0800, 16'sh0800, 16'sh0800);
      // w derivatives do not count for a 2D texture, whose w is always zero
      out_chk(3'h7, 24'h400, 24'h400, 24'h0, (i % 3 == 2) ? 16'h0 : 16'h0200,
              i % 3 == 2);
    end
    u_cfl_src.derivs(16'sh0200, 6, 16'sh0);
    smp(16'sh0800, 16'sh0800, 16'sh0800);
    out_chk(3'h7, 24'h400, 24'h400, 24'h0, 16'h0100, 1'b0);
    // a line only sees derivatives along its own direction
    u_cfl_src.derivs(16'sh0, 0, 16'sh0400);
    u_cfl_src.line(1'b1, 16'sh4000, 16'sh0);
    smp(16'sh0800, 16'sh0800, 16'sh0800);
    out_chk(3'h7, 24'h400, 24'h400, 24'h0, 16'h0200, 1'b0);
    u_cfl_src.line(1'b1, 16'sh0, 16'sh4000);
    smp(16'sh0800, 16'sh0800, 16'sh0800);
    out_chk(3'h7, 24'h400, 24'h400, 24'h0, 16'h8000, 1'b1);
    u_cfl_src.line(1'b0, 16'sh0, 16'sh0);
    $display("t_lod done");
  endtask

  task automatic t_bias();
    logic hb[5] = '{0, 1, 1, 1, 1};
    logic ff[5] = '{1, 0, 1, 1, 1};
    logic signed [15:0] b[5] = '{16'sh0800, 16'sh0800, 16'sh0800, 16'sh0200, -16'sh2C00};
    logic [15:0] e[5] = '{16'h0C00, 16'h0C00, 16'h1000, 16'h0E00, 16'hF000};
    wr(ADDR_BIAS, 32'h0C00);
    u_cfl_src.derivs(16'sh0100, 6, 16'sh0);
    for (int i = 0; i < 5; i++) begin
      u_cfl_src.opts(hb[i], ff[i], b[i], 1'b0, 6'sh0, 6'sh0, 6'sh0);
      smp(16'sh0800, 16'sh0800, 16'sh0800);
      out_chk(3'h7, 24'h400, 24'h400, 24'h0, e[i], $signed(e[i]) <= 0);
    end
    u_cfl_src.opts(1'b0, 1'b0, 16'sh0, 1'b0, 6'sh0, 6'sh0, 6'sh0);
    wr(ADDR_BIAS, 32'h0);
    wr(ADDR_LOD_MAX, 32'h0100);
    u_cfl_src.derivs(16'sh0400, 6, 16'sh0);
    smp(16'sh0800, 16'sh0800, 16'sh0800);
    out_chk(3'h7, 24'h400, 24'h400, 24'h0, 16'h0100, 1'b0);
    wr(ADDR_LOD_MAX, 32'h7FFF);
    wr(ADDR_LOD_MIN, 32'h0300);
    smp(16'sh0800, 16'sh0800, 16'sh0800);
    out_chk(3'h7, 24'h400, 24'h400, 24'h0, 16'h0300, 1'b0);
    wr(ADDR_LOD_MIN, 32'h8000);
    u_cfl_src.derivs(16'sh0100, 6, 16'sh0);
    $display("t_bias done");
  endtask

  task automatic t_tex();
    logic [23:0] eu[7] = '{24'h500, 24'h500, 24'h500, 24'h500, 24'h180, 24'h100, 24'h500};
    logic [23:0] ev[7] = '{24'h0, 24'h0, 24'h100, 24'h100, 24'hFFFF80, 24'hFFFF00, 24'h100};
    wr(ADDR_SIZE_WH, 32'h0004_0008);
    wr(ADDR_SIZE_D, 32'h2);
    u_cfl_src.opts(1'b0, 1'b0, 16'sh0, 1'b1, 6'sh1, -6'sh1, 6'sh3);
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_CTRL, 32'(i) << 2);
      smp(16'sh0800, 16'sh0800, 16'sh0800);
      out_chk(3'h7, eu[i], ev[i], (i == 6) ? 24'h400 : 24'h0, 16'h0, 1'b1);
    end
    wr(ADDR_CTRL, 32'h8);
    u_cfl_src.opts(1'b0, 1'b0, 16'sh0, 1'b0, 6'sh1, -6'sh1, 6'sh3);
    smp(16'sh0800, 16'sh0800, 16'sh0800);
    out_chk(3'h7, 24'h400, 24'h200, 24'h0, 16'h0, 1'b1);
    $display("t_tex done");
  endtask

  task automatic t_seam();
    logic [31:0] c[4] = '{32'h5B6, 32'h5B5, 32'h5B7, 32'h5AB};
    logic [7:0] e[4] = '{8'h78, 8'h00, 8'hAB, 8'h78};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, c[i]);
      rd(ADDR_CTRL, c[i]);
      smp(16'sh1000, 16'sh0, 16'sh0);
      chk("steer", {24'h0, out_wrap_s, out_wrap_t, out_wrap_r, out_seam_fetch,
                    out_corner_avg}, {24'h0, e[i]});
    end
    $display("t_seam done");
  endtask

  task automatic t_pipe();
    wr(ADDR_CTRL, 32'h14);
    u_cfl_src.send(16'sh1000, 16'sh0, 16'sh0);
    u_cfl_src.send(16'sh0, -16'sh1000, 16'sh0);
    u_cfl_src.send(16'sh0, 16'sh0, 16'sh1000);
    u_cfl_src.idle();
    n_smp += 3;
    for (int i = 0; i < 4; i++) begin
      #1;
      chk("valid", {31'h0, out_valid}, {31'h0, i < 3});
      if (i < 3) chk("face", {29'h0, out_face}, 32'(i == 0 ? 0 : i == 1 ? 3 : 4));
      @(posedge core_clk);
    end
    rd(ADDR_COUNT, n_smp);
    $display("t_pipe done");
  endtask

  initial begin
    num_errors = 0;
    n_checks = 0;
    n_smp = 0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_faces();
    t_lod();
    t_bias();
    t_tex();
    t_seam();
    t_pipe();
    stop_test();
  end
endmodule // cube_face_select_lod_calc_test
